// [design/rpsc_pkg.sv]
// rpsc_pkg: constants for the reset, park and test strap control block
// assumes a 100 MHz system clock
`default_nettype none
package rpsc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int STRAP_DELAY_NS = 1500;
    localparam int STRAP_DELAY_CYC = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRAP_CNT_W = 12;
    localparam int STRAP_W = 8;
    localparam logic [STRAP_W-1:0] STRAP_NORMAL = 8'h00;
    localparam logic [STRAP_W-1:0] TEST_OUT_RESET = 8'h00;

    typedef enum logic [1:0] {
        RPSC_HOLD,
        RPSC_WAIT,
        RPSC_RUN
    } rpsc_state_t;
endpackage
`default_nettype wire

// [design/rpsc_top.sv]
// rpsc_top: power-on reset release, fast park and test strap handling
// assumes clk is stable before power_on_reset_n is released
// Behaviour
// (R1) a low fast park request puts the mirror array promptly into its parked state.
// (R2) the supervisor asks for a fast park only when power loss is imminent.
// (R3) self-configuration starts on the low-to-high edge of the power-on reset.
// (R4) the power-on reset is released only after supplies and clocks are stable.
// (R5) while the power-on reset is low no output is in its active state.
// (R6) strap pins stay undriven, with weak pulldowns only, while reset is low.
// (R7) about 1.5 us after reset release the straps are sampled, then driven as outputs.
// (R8) any strap sampled high selects a test mode, all low selects normal operation.
// (R9) the board ties the manufacturing test enable low for normal operation.
// (R10) the board holds the test port reset low through a resistor.
// (R11) the strap mode is latched once and held until the next power-on reset.
`timescale 1ns/100ps
`default_nettype none
module rpsc_top
    import rpsc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic power_on_reset_n,
    input wire logic fast_park_request_n,
    input wire logic manufacturing_test_enable,
    input wire logic internal_test_port_reset_n,
    input wire logic [STRAP_W-1:0] test_strap_in,
    output logic [STRAP_W-1:0] test_strap_out,
    output logic [STRAP_W-1:0] test_strap_oe,
    output logic [STRAP_W-1:0] test_strap_pulldown_en,
    input wire logic [STRAP_W-1:0] test_out_data,
    output logic config_start,
    output logic config_active,
    output logic park_mirrors,
    output logic [STRAP_W-1:0] strap_mode,
    output logic test_mode
);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [1:0] por_sync_reg;
    logic [1:0] park_sync_reg;
    logic [1:0] hwt_sync_reg;
    logic [1:0] tp_sync_reg;
    logic [STRAP_W-1:0] strap_meta_reg;
    logic [STRAP_W-1:0] strap_sync_reg;
    logic por_d_reg;
    wire por_ok = por_sync_reg[1];

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            por_sync_reg <= 2'h0;
            park_sync_reg <= 2'h3;
            hwt_sync_reg <= 2'h0;
            tp_sync_reg <= 2'h3;
            strap_meta_reg <= '0;
            strap_sync_reg <= '0;
            por_d_reg <= 1'b0;
        end
        else
        begin
            por_sync_reg <= {por_sync_reg[0], power_on_reset_n};
            park_sync_reg <= {park_sync_reg[0], fast_park_request_n};
            hwt_sync_reg <= {hwt_sync_reg[0], manufacturing_test_enable};
            tp_sync_reg <= {tp_sync_reg[0], internal_test_port_reset_n};
            strap_meta_reg <= test_strap_in;
            strap_sync_reg <= strap_meta_reg;
            por_d_reg <= por_ok;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    rpsc_state_t state_reg;
    logic [STRAP_CNT_W-1:0] cnt_reg;
    wire por_rise = por_ok && !por_d_reg; // R3
    wire sample_now = (state_reg == RPSC_WAIT) && (cnt_reg == STRAP_CNT_W'(STRAP_DELAY_CYC - 1));

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= RPSC_HOLD;
            cnt_reg <= '0;
        end
        else if (!por_ok)
        begin
            state_reg <= RPSC_HOLD; // R5
            cnt_reg <= '0;
        end
        else
        begin
            case (state_reg)
                RPSC_HOLD:
                begin
                    if (por_rise)
                    begin
                        state_reg <= RPSC_WAIT; // R3
                        cnt_reg <= '0;
                    end
                end
                RPSC_WAIT:
                begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (sample_now)
                    begin
                        state_reg <= RPSC_RUN; // R7
                    end
                end
                RPSC_RUN:
                begin
                    cnt_reg <= '0;
                end
                default:
                begin
                    state_reg <= RPSC_HOLD;
                end
            endcase
        end
    end

    // ----------------------------------------
    // strap latch and outputs
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            strap_mode <= STRAP_NORMAL;
        end
        else if (!por_ok)
        begin
            strap_mode <= STRAP_NORMAL;
        end
        else if (sample_now)
        begin
            strap_mode <= strap_sync_reg | {STRAP_W{hwt_sync_reg[1]}}; // R8 R11
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            test_strap_out <= TEST_OUT_RESET;
            test_strap_oe <= '0;
            config_start <= 1'b0;
            park_mirrors <= 1'b0;
        end
        else
        begin
            config_start <= por_rise; // R3
            park_mirrors <= por_ok && !park_sync_reg[1]; // R1 R5
            if (por_ok && state_reg == RPSC_RUN)
            begin
                test_strap_out <= test_out_data; // R7
                test_strap_oe <= '1;
            end
            else
            begin
                test_strap_out <= TEST_OUT_RESET; // R6
                test_strap_oe <= '0;
            end
        end
    end

    assign test_strap_pulldown_en = ~test_strap_oe; // R6
    assign config_active = (state_reg == RPSC_RUN) && !tp_sync_reg[1];
    assign test_mode = |strap_mode; // R8

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_strap_hiz_reset: assert property (@(posedge clk) disable iff (!resetn) // R6
        !por_sync_reg[1] |=> test_strap_oe == '0)
        else $error("straps driven in reset");
    a_no_active_reset: assert property (@(posedge clk) disable iff (!resetn) // R5
        !por_sync_reg[1] |=> !park_mirrors && !config_start)
        else $error("output active in reset");
    a_outputs_idle: assert property (@(posedge clk) disable iff (!resetn) // R5
        !por_ok |=> !config_active && !test_mode && test_strap_out == TEST_OUT_RESET)
        else $error("status active in reset");
    a_hold_in_reset: assert property (@(posedge clk) disable iff (!resetn) // R5
        !por_ok |=> state_reg == RPSC_HOLD)
        else $error("sequencer left hold in reset");
    a_park_prompt: assert property (@(posedge clk) disable iff (!resetn) // R1
        (por_ok && !park_sync_reg[1]) |=> park_mirrors)
        else $error("park not taken");
    a_park_release: assert property (@(posedge clk) disable iff (!resetn) // R1
        (por_ok && park_sync_reg[1]) |=> !park_mirrors)
        else $error("park without request");
    a_config_on_rise: assert property (@(posedge clk) disable iff (!resetn) // R3
        $rose(por_ok) |=> config_start)
        else $error("config not started");
    a_config_pulse: assert property (@(posedge clk) disable iff (!resetn) // R3
        config_start |=> !config_start)
        else $error("config start too long");
    a_sample_delay: assert property (@(posedge clk) disable iff (!resetn || !por_ok) // R7
        (state_reg == RPSC_HOLD) ##1 (state_reg == RPSC_WAIT) |-> ##150 (state_reg == RPSC_RUN))
        else $error("strap sample timing wrong");
    a_drive_after: assert property (@(posedge clk) disable iff (!resetn) // R7
        (state_reg == RPSC_RUN && por_ok) |=> test_strap_oe == '1)
        else $error("straps not driven");
    a_mode_stable: assert property (@(posedge clk) disable iff (!resetn) // R11
        (state_reg == RPSC_RUN && por_ok) |=> $stable(strap_mode))
        else $error("mode changed");
    a_mode_select: assert property (@(posedge clk) disable iff (!resetn) // R8
        (sample_now && strap_sync_reg == '0 && !hwt_sync_reg[1]) |=> !test_mode)
        else $error("normal mode not selected");
    a_mode_test: assert property (@(posedge clk) disable iff (!resetn) // R8
        (sample_now && strap_sync_reg != '0) |=> test_mode)
        else $error("test mode not selected");

    // ----------------------------------------
    // covers
    // ----------------------------------------
    c_boot: cover property (@(posedge clk) disable iff (!resetn) state_reg == RPSC_RUN);
    c_park: cover property (@(posedge clk) disable iff (!resetn) park_mirrors);
    c_test: cover property (@(posedge clk) disable iff (!resetn) test_mode);
    c_gate: cover property (@(posedge clk) disable iff (!resetn) state_reg == RPSC_RUN && !config_active);
    c_hw_test: cover property (@(posedge clk) disable iff (!resetn) sample_now && hwt_sync_reg[1]);
endmodule
`default_nettype wire

// [bench/rpsc_pmic_model.sv]
// rpsc_pmic_model: supervisor driving power-on reset and fast park
// assumes the bench raises por_ok only once clocks are stable
`timescale 1ns/100ps
`default_nettype none
module rpsc_pmic_model
(
    input wire logic por_ok,
    input wire logic power_fail,
    input wire logic board_test_level,
    input wire logic board_tp_level,
    output logic power_on_reset_n,
    output logic fast_park_request_n,
    output logic manufacturing_test_enable,
    output logic internal_test_port_reset_n
);
    assign power_on_reset_n = por_ok;
    assign fast_park_request_n = ~power_fail;
    assign manufacturing_test_enable = board_test_level;
    assign internal_test_port_reset_n = board_tp_level;
endmodule
`default_nettype wire

// [bench/reset_park_test_strap_control_tb.sv]
// reset_park_test_strap_control_tb: boot, strap and park checks
// assumes 100 MHz clk, strap wire resolved from oe and board pullups
`timescale 1ns/100ps
`default_nettype none
module reset_park_test_strap_control_tb;
    import rpsc_pkg::*;
    logic clk = 0;
    logic resetn = 0;
    logic por_ok = 0;
    logic power_fail = 0;
    logic hw_test = 0;
    logic tp_level = 0;
    logic hwt_pin, tp_pin_n;
    logic [STRAP_W-1:0] pull_up = 8'h00;
    logic [STRAP_W-1:0] out_data = 8'h5a;
    logic [STRAP_W-1:0] s_out, s_oe, s_pd, s_mode, s_wire;
    logic por_n, park_n, cfg_start, cfg_act, park, tmode;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    // ----------------------------------------
    // clock, strap wire, timeout
    // ----------------------------------------
    always #5 clk = ~clk;
    assign s_wire = (s_oe & s_out) | (~s_oe & pull_up);
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_errors++;
            $display("mismatch at %0t: timeout", $time);
            finish_test();
        end
    end
    rpsc_pmic_model pmic_u (.por_ok(por_ok), .power_fail(power_fail), .board_test_level(hw_test),
        .board_tp_level(tp_level), .power_on_reset_n(por_n), .fast_park_request_n(park_n),
        .manufacturing_test_enable(hwt_pin), .internal_test_port_reset_n(tp_pin_n));
    rpsc_top dut_u (.clk(clk), .resetn(resetn), .power_on_reset_n(por_n), .fast_park_request_n(park_n),
        .manufacturing_test_enable(hwt_pin), .internal_test_port_reset_n(tp_pin_n), .test_strap_in(s_wire),
        .test_strap_out(s_out), .test_strap_oe(s_oe), .test_strap_pulldown_en(s_pd),
        .test_out_data(out_data), .config_start(cfg_start), .config_active(cfg_act),
        .park_mirrors(park), .strap_mode(s_mode), .test_mode(tmode));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d checked %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic t_hold();
        @(posedge clk);
        por_ok <= 0;
        power_fail <= 1;
        repeat (10) @(posedge clk);
        #1;
        chk(s_oe, 8'h00);
        chk(s_pd, 8'hff);
        chk({7'h00, park}, 8'h00);
        chk({5'h00, cfg_start, cfg_act, tmode}, 8'h00);
        @(posedge clk);
        power_fail <= 0;
    endtask
    task automatic t_boot(input logic [7:0] pu);
        int n;
        @(posedge clk);
        pull_up <= pu;
        out_data <= 8'h5a;
        por_ok <= 1;
        n = 0;
        while (cfg_start !== 1'b1 && n < 10)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({7'h00, cfg_start}, 8'h01);
        while (s_oe !== 8'hff && n < 300)
        begin
            chk(s_oe, 8'h00);
            @(posedge clk);
            #1;
            n++;
        end
        chk({7'h00, n >= 148 && n <= 160}, 8'h01);
        chk(s_mode, pu);
        chk({6'h00, tmode, cfg_act}, {6'h00, |pu, 1'b1});
        chk(s_out, 8'h5a);
        @(posedge clk);
        pull_up <= ~pu;
        out_data <= 8'ha5;
        repeat (5) @(posedge clk);
        #1;
        chk(s_mode, pu);
        chk(s_out, 8'ha5);
    endtask
    task automatic t_park();
        @(posedge clk);
        power_fail <= 1;
        repeat (5) @(posedge clk);
        #1;
        chk({7'h00, park}, 8'h01);
        @(posedge clk);
        power_fail <= 0;
        repeat (5) @(posedge clk);
        #1;
        chk({7'h00, park}, 8'h00);
    endtask
    task automatic t_board();
        @(posedge clk);
        hw_test <= 1;
        tp_level <= 1;
        pull_up <= 8'h00;
        por_ok <= 1;
        repeat (160) @(posedge clk);
        #1;
        chk(s_mode, 8'hff);
        chk({6'h00, tmode, cfg_act}, 8'h02);
        @(posedge clk);
        hw_test <= 0;
        tp_level <= 0;
        repeat (5) @(posedge clk);
        #1;
        chk(s_mode, 8'hff);
        chk({7'h00, cfg_act}, 8'h01);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        resetn <= 1;
        t_hold();
        t_boot(8'h00);
        t_park();
        t_hold();
        t_boot(8'h81);
        t_hold();
        t_boot(8'h10);
        t_hold();
        t_board();
        finish_test();
    end
endmodule
`default_nettype wire
